/* common/dmt_defs.vh */
`ifndef DMT_DEFS_VH
`define DMT_DEFS_VH

// Object indices
`define DMT_IDX_COMM_BASE      16'h1000
`define DMT_IDX_VENDOR_BASE    16'h2000
`define DMT_IDX_PROFILE_BASE   16'h6000
`define DMT_IDX_LIMIT_FUNC     16'h2110
`define DMT_IDX_TQ_SCALE       16'h221c
`define DMT_IDX_TQ_OFFSET      16'h221d
`define DMT_IDX_TQ_FILTER      16'h2228
`define DMT_IDX_AIN_FUNC       16'h222b
`define DMT_IDX_SPD_SRC        16'h230d
`define DMT_IDX_SPD_LIMIT      16'h230e
`define DMT_IDX_CTRL_MODE      16'h3000

// Reset values
`define DMT_RST_TQ_SCALE       16'h0064
`define DMT_RST_TQ_OFFSET      16'h0000
`define DMT_RST_TQ_FILTER      16'h0000
`define DMT_RST_AIN_FUNC       16'h0000
`define DMT_RST_SPD_SRC        16'h0000
`define DMT_RST_SPD_LIMIT      16'h03e8
`define DMT_RST_LIMIT_FUNC     16'h0000
`define DMT_RST_CTRL_MODE      16'h0001

// Scale range, 0.1 %/V
`define DMT_SCALE_MIN          16'hfc18
`define DMT_SCALE_MAX          16'h03e8

// Field values
`define DMT_LIMIT_FUNC_ANALOG  16'h0004
`define DMT_SPD_SRC_STORED     16'h0000
`define DMT_SPD_SRC_MAXIMUM    16'h0001

// Operating modes, 2 bits
`define DMT_OP_INDEX           2'h0
`define DMT_OP_PULSE           2'h1
`define DMT_OP_SPEED           2'h2
`define DMT_OP_TORQUE          2'h3

// Control mode settings
`define DMT_CM_INDEX           4'h0
`define DMT_CM_PULSE           4'h1
`define DMT_CM_SPEED           4'h2
`define DMT_CM_TORQUE          4'h3
`define DMT_CM_PULSE_INDEX     4'h4
`define DMT_CM_PULSE_SPEED     4'h5
`define DMT_CM_PULSE_TORQUE    4'h6
`define DMT_CM_SPEED_TORQUE    4'h7
`define DMT_CM_INDEX_SPEED     4'h8
`define DMT_CM_INDEX_TORQUE    4'h9

// Object data type codes
`define DMT_TYPE_SINT          3'h0
`define DMT_TYPE_USINT         3'h1
`define DMT_TYPE_INT           3'h2
`define DMT_TYPE_UINT          3'h3
`define DMT_TYPE_DINT          3'h4
`define DMT_TYPE_UDINT         3'h5
`define DMT_TYPE_FP32          3'h6
`define DMT_TYPE_STRING        3'h7

`endif

/* verilog/dmt_sync2.v */
`timescale 1ns/10ps
`default_nettype none
module dmt_sync2 (
	input  wire clk,   // System clock
	input  wire rstn,  // Synchronous reset, active low
	input  wire din,   // Asynchronous level
	output wire dout   // Synchronised level
);
	reg stage1;
	reg stage2;

	// Two stages; only stage2 is visible outside
	always @(posedge clk) begin
		if (!rstn) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
		end else begin
			stage1 <= din;
			stage2 <= stage1;
		end
	end

	assign dout = stage2;
endmodule
`default_nettype wire

/* verilog/dmt_mode_select.v */
`timescale 1ns/10ps
`default_nettype none
`include "dmt_defs.vh"
module dmt_mode_select (
	input  wire [3:0] ctrlMode,    // Control-mode setting
	input  wire       modeSelect,  // Synchronised mode-select input
	output reg  [1:0] opMode,      // Resulting operating mode
	output reg        modeValid    // Control mode is a known setting
);
	// Mode decode; unknown settings fall back to pulse position and flag it
	always @* begin
		opMode    = `DMT_OP_PULSE;
		modeValid = 1'b1;
		case (ctrlMode)
			`DMT_CM_INDEX:        opMode = `DMT_OP_INDEX;
			`DMT_CM_PULSE:        opMode = `DMT_OP_PULSE;
			`DMT_CM_SPEED:        opMode = `DMT_OP_SPEED;
			`DMT_CM_TORQUE:       opMode = `DMT_OP_TORQUE;
			`DMT_CM_PULSE_INDEX:  opMode = modeSelect ? `DMT_OP_INDEX : `DMT_OP_PULSE;
			`DMT_CM_PULSE_SPEED:  opMode = modeSelect ? `DMT_OP_SPEED : `DMT_OP_PULSE;
			`DMT_CM_PULSE_TORQUE: opMode = modeSelect ? `DMT_OP_TORQUE : `DMT_OP_PULSE;
			`DMT_CM_SPEED_TORQUE: opMode = modeSelect ? `DMT_OP_TORQUE : `DMT_OP_SPEED;
			`DMT_CM_INDEX_SPEED:  opMode = modeSelect ? `DMT_OP_SPEED : `DMT_OP_INDEX;
			// indexed or torque, back to default on release
			`DMT_CM_INDEX_TORQUE: opMode = modeSelect ? `DMT_OP_TORQUE : `DMT_OP_INDEX;
			default: begin
				opMode    = `DMT_OP_PULSE;
				modeValid = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

/* verilog/dmt_drive_config.v */
`timescale 1ns/10ps
`default_nettype none
`include "dmt_defs.vh"
module dmt_drive_config #(
	parameter MAX_SPEED_RPM = 16'h0bb8  // Motor maximum speed, rpm
) (
	input  wire        clk,            // System clock, 100 MHz
	input  wire        rstn,           // Synchronous reset, active low
	input  wire        objWrite,       // Object write strobe, one cycle
	input  wire        objRead,        // Object read strobe, one cycle
	input  wire [15:0] objIndex,       // Object index
	input  wire [15:0] objWdata,       // Object write value
	output reg  [15:0] objRdata,       // Object read value
	output reg         objAck,         // Access accepted, one cycle
	output reg         objErr,         // Access refused, one cycle
	output reg  [2:0]  objType,        // Data type of addressed object
	input  wire        modeSelectPin,  // Digital mode-select input, async
	input  wire [15:0] analogIn,       // Analog torque input, signed mV
	output reg  [1:0]  opMode,         // Active operating mode
	output reg         torqueOp,       // Torque operation active
	output reg  [31:0] torqueCmd,      // Torque command, 0.001 % rated
	output reg         torqueCmdValid, // Command output meaningful
	output reg  [31:0] torqueLimit,    // Torque limit, 0.001 % rated
	output reg         torqueLimitOn,  // Analog torque limit active
	output reg  [15:0] speedLimit      // Speed cap in torque op, rpm
);
	// Parameter storage
	reg [15:0] torqueInputScale;
	reg [15:0] torqueInputOffset;
	reg [15:0] torqueCommandFilterTime;
	reg [15:0] analogInputFunctionSelect;
	reg [15:0] speedLimitSourceSelect;
	reg [15:0] torqueModeSpeedLimit;
	reg [15:0] torqueLimitFunction;
	reg [15:0] controlMode;

	wire       modeSelectSync;
	wire [1:0] next_opMode;
	wire       modeValid;

	// Pin passes two flops before decode
	dmt_sync2 u_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  (modeSelectPin),
		.dout (modeSelectSync)
	);

	dmt_mode_select u_mode (
		.ctrlMode   (controlMode[3:0]),
		.modeSelect (modeSelectSync),
		.opMode     (next_opMode),
		.modeValid  (modeValid)
	);

	// Address decode
	wire hitScale   = (objIndex == `DMT_IDX_TQ_SCALE);
	wire hitOffset  = (objIndex == `DMT_IDX_TQ_OFFSET);
	wire hitFilter  = (objIndex == `DMT_IDX_TQ_FILTER);
	wire hitAinFunc = (objIndex == `DMT_IDX_AIN_FUNC);
	wire hitSpdSrc  = (objIndex == `DMT_IDX_SPD_SRC);
	wire hitSpdLim  = (objIndex == `DMT_IDX_SPD_LIMIT);
	wire hitLimFunc = (objIndex == `DMT_IDX_LIMIT_FUNC);
	wire hitCtrl    = (objIndex == `DMT_IDX_CTRL_MODE);
	wire hitAny     = hitScale | hitOffset | hitFilter | hitAinFunc |
	                  hitSpdSrc | hitSpdLim | hitLimFunc | hitCtrl;

	wire scaleInRange = ($signed(objWdata) >= $signed(`DMT_SCALE_MIN)) &&
	                    ($signed(objWdata) <= $signed(`DMT_SCALE_MAX));
	// Speed source accepts only its two settings
	wire spdSrcOk     = (objWdata == `DMT_SPD_SRC_STORED) ||
	                    (objWdata == `DMT_SPD_SRC_MAXIMUM);
	// Control mode above 9 is refused rather than stored
	wire ctrlOk       = (objWdata <= {12'h000, `DMT_CM_INDEX_TORQUE});
	wire writeOk      = hitAny && !(hitScale && !scaleInRange) &&
	                    !(hitSpdSrc && !spdSrcOk) && !(hitCtrl && !ctrlOk);

	// Parameter writes; retention across power is the store logic's job
	always @(posedge clk) begin
		if (!rstn) begin
			torqueInputScale          <= `DMT_RST_TQ_SCALE;
			torqueInputOffset         <= `DMT_RST_TQ_OFFSET;
			torqueCommandFilterTime   <= `DMT_RST_TQ_FILTER;
			analogInputFunctionSelect <= `DMT_RST_AIN_FUNC;
			speedLimitSourceSelect    <= `DMT_RST_SPD_SRC;
			torqueModeSpeedLimit      <= `DMT_RST_SPD_LIMIT;
			torqueLimitFunction       <= `DMT_RST_LIMIT_FUNC;
			controlMode               <= `DMT_RST_CTRL_MODE;
		end else if (objWrite && writeOk) begin
			if (hitScale)
				torqueInputScale <= objWdata;
			if (hitOffset)
				torqueInputOffset <= objWdata;
			if (hitFilter)
				torqueCommandFilterTime <= objWdata;
			if (hitAinFunc)
				analogInputFunctionSelect <= objWdata;
			if (hitSpdSrc)
				speedLimitSourceSelect <= objWdata;
			if (hitSpdLim)
				torqueModeSpeedLimit <= objWdata;
			if (hitLimFunc)
				torqueLimitFunction <= objWdata;
			if (hitCtrl)
				controlMode <= objWdata;
		end
	end

	// Read mux and type of each object
	reg [15:0] readValue;
	reg [2:0]  readType;
	always @* begin
		readValue = 16'h0000;
		readType  = `DMT_TYPE_UINT;
		if (hitScale)
			readValue = torqueInputScale;
		if (hitOffset) begin
			readValue = torqueInputOffset;
			readType  = `DMT_TYPE_INT;
		end
		if (hitFilter)
			readValue = torqueCommandFilterTime;
		if (hitAinFunc)
			readValue = analogInputFunctionSelect;
		if (hitSpdSrc)
			readValue = speedLimitSourceSelect;
		if (hitSpdLim)
			readValue = torqueModeSpeedLimit;
		if (hitLimFunc)
			readValue = torqueLimitFunction;
		if (hitCtrl)
			readValue = controlMode;
	end

	wire inVendor  = (objIndex >= `DMT_IDX_VENDOR_BASE) && (objIndex < `DMT_IDX_PROFILE_BASE);

	// Access answer one cycle after the strobe
	always @(posedge clk) begin
		if (!rstn) begin
			objRdata <= 16'h0000;
			objAck   <= 1'b0;
			objErr   <= 1'b0;
			objType  <= `DMT_TYPE_UINT;
		end else begin
			objAck <= (objWrite && writeOk) || (objRead && hitAny && inVendor);
			objErr <= (objWrite && !writeOk) || (objRead && !hitAny);
			if (objRead && hitAny) begin
				objRdata <= readValue;
				objType  <= readType;
			end
		end
	end

	// Analog input with offset applied, signed mV
	wire signed [16:0] adjIn  = $signed({analogIn[15], analogIn}) -
	                            $signed({torqueInputOffset[15], torqueInputOffset});
	// scale in 0.1 %/V times mV gives 0.0001 %; /10 shown as 0.001 %
	wire signed [33:0] prodRaw = adjIn * $signed({{1{torqueInputScale[15]}}, torqueInputScale});
	// Upper product bits are only sign copies for inputs within the 16-bit range
	wire        [31:0] product = prodRaw[31:0];
	// Signed value in 0.001 % units: product is 0.0001 %, divide by ten
	wire signed [31:0] pctMilli = $signed(product) / 32'sd10;

	wire isTorque = (next_opMode == `DMT_OP_TORQUE);

	// Outputs follow the decoded mode and parameters
	always @(posedge clk) begin
		if (!rstn) begin
			opMode         <= `DMT_OP_PULSE;
			torqueOp       <= 1'b0;
			torqueCmd      <= 32'h0000_0000;
			torqueCmdValid <= 1'b0;
			torqueLimit    <= 32'h0000_0000;
			torqueLimitOn  <= 1'b0;
			speedLimit     <= `DMT_RST_SPD_LIMIT;
		end else begin
			opMode   <= next_opMode;
			torqueOp <= isTorque;
			// scale is command gain at 10 V
			torqueCmd      <= isTorque ? pctMilli : 32'h0000_0000;
			torqueCmdValid <= isTorque && modeValid;
			torqueLimitOn <= !isTorque && (torqueLimitFunction == `DMT_LIMIT_FUNC_ANALOG);
			torqueLimit   <= (!isTorque && (torqueLimitFunction == `DMT_LIMIT_FUNC_ANALOG)) ?
			                 (pctMilli[31] ? -pctMilli : pctMilli) : 32'h0000_0000;
			if (speedLimitSourceSelect == `DMT_SPD_SRC_MAXIMUM)
				speedLimit <= MAX_SPEED_RPM;
			else
				speedLimit <= torqueModeSpeedLimit;
		end
	end

endmodule
`default_nettype wire

/* tb/dmt_drive_config_props.sv */
`timescale 1ns/10ps
`default_nettype none
// Watches the object port and the derived drive outputs; one clock domain only
module dmt_drive_config_props #(
	parameter MAX_SPEED_RPM = 16'h0bb8  // Motor maximum speed, rpm
) (
	input wire logic        clk,            // Clock
	input wire logic        rstn,           // Reset, active low
	input wire logic        objWrite,       // Write strobe
	input wire logic        objRead,        // Read strobe
	input wire logic [15:0] objIndex,       // Object index
	input wire logic [15:0] objWdata,       // Write value
	input wire logic [15:0] objRdata,       // Read value
	input wire logic        objAck,         // Accepted
	input wire logic        objErr,         // Refused
	input wire logic [2:0]  objType,        // Type code
	input wire logic        modeSelectPin,  // Mode-select pin
	input wire logic [15:0] analogIn,       // Analog input, mV
	input wire logic [1:0]  opMode,         // Operating mode
	input wire logic        torqueOp,       // Torque operation
	input wire logic [31:0] torqueCmd,      // Torque command
	input wire logic        torqueCmdValid, // Command meaningful
	input wire logic [31:0] torqueLimit,    // Torque limit
	input wire logic        torqueLimitOn,  // Limit active
	input wire logic [15:0] speedLimit      // Speed cap, rpm
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Accepted write choosing the motor maximum as speed cap
	sequence srcMaxWrite;
		objWrite && objIndex == 16'h230d && objWdata == 16'h0001 ##1 objAck;
	endsequence
	AST_ANSWER: assert property ((objWrite || objRead) |=> (objAck ^ objErr))
		else $error("access not answered in one cycle");
	AST_NO_SPURIOUS: assert property ((objAck || objErr) |-> $past(objWrite || objRead))
		else $error("answer without access");
	AST_UNKNOWN_IDX: assert property (objRead && (objIndex == 16'h6000 || objIndex == 16'h1000) |=> objErr)
		else $error("unheld index accepted");
	AST_SCALE_RANGE: assert property (objWrite && objIndex == 16'h221c &&
		($signed(objWdata) > 1000 || $signed(objWdata) < -1000) |=> objErr)
		else $error("out of range scale accepted");
	AST_MODE_RANGE: assert property (objWrite && objIndex == 16'h3000 && objWdata > 16'h0009 |=> objErr)
		else $error("unknown control mode accepted");
	AST_SRC_RANGE: assert property (objWrite && objIndex == 16'h230d && objWdata > 16'h0001 |=> objErr)
		else $error("unknown speed source accepted");
	AST_SPEED_MAX: assert property (srcMaxWrite |-> ##[0:3] speedLimit == MAX_SPEED_RPM)
		else $error("speed cap not at motor maximum");
	AST_CMD_GATED: assert property (torqueCmd != 0 |-> torqueCmdValid)
		else $error("torque command outside torque operation");
	AST_LIMIT_GATED: assert property (torqueLimit != 0 |-> torqueLimitOn && !torqueCmdValid)
		else $error("torque limit while not active");
	AST_RESET_STATE: assert property ($rose(rstn) |-> opMode == 2'h1 && speedLimit == 16'h03e8)
		else $error("wrong state after reset");
endmodule
bind dmt_drive_config dmt_drive_config_props #(.MAX_SPEED_RPM(MAX_SPEED_RPM)) uProps (.clk(clk), .rstn(rstn),
	.objWrite(objWrite), .objRead(objRead), .objIndex(objIndex), .objWdata(objWdata), .objRdata(objRdata),
	.objAck(objAck), .objErr(objErr), .objType(objType), .modeSelectPin(modeSelectPin), .analogIn(analogIn),
	.opMode(opMode), .torqueOp(torqueOp), .torqueCmd(torqueCmd), .torqueCmdValid(torqueCmdValid),
	.torqueLimit(torqueLimit), .torqueLimitOn(torqueLimitOn), .speedLimit(speedLimit));
`default_nettype wire

/* tb/dmt_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Host controller issuing one-cycle object accesses and waiting for the answer
module dmt_host_model (
	input  wire logic        clk,      // Clock
	output var  logic        objWrite, // Write strobe
	output var  logic        objRead,  // Read strobe
	output var  logic [15:0] objIndex, // Object index
	output var  logic [15:0] objWdata, // Write value
	input  wire logic [15:0] objRdata, // Read value
	input  wire logic        objAck,   // Accepted
	input  wire logic        objErr    // Refused
);
	initial begin
		objWrite = 1'b0;
		objRead = 1'b0;
		objIndex = 16'h0000;
		objWdata = 16'h0000;
	end
	// Strobe is a single-cycle pulse; a missing answer reads as refusal
	task access(input logic wr, input logic [15:0] idx, input logic [15:0] data,
		output logic err, output logic [15:0] rd);
		integer n;
		err = 1'b1;
		rd = 16'hxxxx;
		@(posedge clk);
		objWrite <= wr;
		objRead <= ~wr;
		objIndex <= idx;
		objWdata <= data;
		@(posedge clk);
		objWrite <= 1'b0;
		objRead <= 1'b0;
		for (n = 0; n < 4; n++) begin
			@(posedge clk);
			if (objAck || objErr) begin
				err = objErr;
				rd = objRdata;
				break;
			end
		end
		// Stale data is not left on the bus
		objWdata <= ~data;
	endtask
endmodule
`default_nettype wire

/* tb/dmt_drive_config_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dmt_defs.vh"
module dmt_drive_config_bench;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        modeSelectPin = 1'b0;
	logic [15:0] analogIn = 16'h0000;
	logic        objWrite, objRead, objAck, objErr, torqueOp, torqueCmdValid, torqueLimitOn, aErr;
	logic [15:0] objIndex, objWdata, objRdata, speedLimit, aRd;
	logic [2:0]  objType;
	logic [1:0]  opMode;
	logic [31:0] torqueCmd, torqueLimit;
	integer      miscompares = 0;
	integer      total_checks = 0;
	integer      seed = 69;
	always #5 clk = ~clk;
	dmt_host_model host (.clk(clk), .objWrite(objWrite), .objRead(objRead), .objIndex(objIndex),
		.objWdata(objWdata), .objRdata(objRdata), .objAck(objAck), .objErr(objErr));
	dmt_drive_config #(.MAX_SPEED_RPM(16'h0bb8)) uut (.clk(clk), .rstn(rstn), .objWrite(objWrite),
		.objRead(objRead), .objIndex(objIndex), .objWdata(objWdata), .objRdata(objRdata), .objAck(objAck),
		.objErr(objErr), .objType(objType), .modeSelectPin(modeSelectPin), .analogIn(analogIn), .opMode(opMode),
		.torqueOp(torqueOp), .torqueCmd(torqueCmd), .torqueCmdValid(torqueCmdValid), .torqueLimit(torqueLimit),
		.torqueLimitOn(torqueLimitOn), .speedLimit(speedLimit));
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One access with its refusal flag compared
	task acc(input logic wr, input logic [15:0] idx, input logic [15:0] data, input logic expErr);
		host.access(wr, idx, data, aErr, aRd);
		chk("objErr", {31'h0, expErr}, {31'h0, aErr});
	endtask
	// Reference operating mode: default when select is low, alternative when high
	function logic [1:0] expMode(input integer cm, input logic s);
		case (cm)
			4: expMode = s ? 2'h0 : 2'h1;
			5: expMode = s ? 2'h2 : 2'h1;
			6: expMode = s ? 2'h3 : 2'h1;
			7: expMode = s ? 2'h3 : 2'h2;
			8: expMode = s ? 2'h2 : 2'h0;
			9: expMode = s ? 2'h3 : 2'h0;
			default: expMode = cm[1:0];
		endcase
	endfunction
	task final_report;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard, far beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		final_report;
	end
	// Main sequence; outputs are compared after the sync and register latency settle
	initial begin
		integer cm, k, sc, r;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		acc(1'b0, `DMT_IDX_TQ_SCALE, 16'h0000, 1'b0);
		chk("scale", 32'h0000_0064, {16'h0000, aRd});
		chk("objType", {29'h0, `DMT_TYPE_UINT}, {29'h0, objType});
		acc(1'b0, `DMT_IDX_SPD_LIMIT, 16'h0000, 1'b0);
		chk("limitValue", 32'h0000_03e8, {16'h0000, aRd});
		chk("speedLimit", 32'h0000_03e8, {16'h0000, speedLimit});
		acc(1'b1, `DMT_IDX_TQ_SCALE, 16'h03e8, 1'b0);
		acc(1'b1, `DMT_IDX_TQ_SCALE, 16'hfc18, 1'b0);
		acc(1'b1, `DMT_IDX_TQ_SCALE, 16'h03e9, 1'b1);
		acc(1'b1, `DMT_IDX_TQ_SCALE, 16'hfc17, 1'b1);
		acc(1'b0, `DMT_IDX_TQ_SCALE, 16'h0000, 1'b0);
		chk("scale", 32'h0000_fc18, {16'h0000, aRd});
		acc(1'b1, `DMT_IDX_CTRL_MODE, 16'h000a, 1'b1);
		acc(1'b0, 16'h6000, 16'h0000, 1'b1);
		acc(1'b0, 16'h1000, 16'h0000, 1'b1);
		// Offset of 20 mV stays in place for the torque test below
		acc(1'b1, `DMT_IDX_TQ_OFFSET, 16'h0014, 1'b0);
		acc(1'b0, `DMT_IDX_TQ_OFFSET, 16'h0000, 1'b0);
		chk("offset", 32'h0000_0014, {16'h0000, aRd});
		chk("objType", {29'h0, `DMT_TYPE_INT}, {29'h0, objType});
		// Plain stored objects take any random word
		r = $random(seed);
		acc(1'b1, `DMT_IDX_TQ_FILTER, r[15:0], 1'b0);
		acc(1'b1, `DMT_IDX_AIN_FUNC, r[31:16], 1'b0);
		acc(1'b0, `DMT_IDX_TQ_FILTER, 16'h0000, 1'b0);
		chk("filter", {16'h0000, r[15:0]}, {16'h0000, aRd});
		acc(1'b0, `DMT_IDX_AIN_FUNC, 16'h0000, 1'b0);
		chk("ainFunc", {16'h0000, r[31:16]}, {16'h0000, aRd});
		$display("test registers done");
		// every control mode, select low, high, low again
		for (cm = 0; cm < 10; cm++) begin
			acc(1'b1, `DMT_IDX_CTRL_MODE, cm[15:0], 1'b0);
			for (k = 0; k < 3; k++) begin
				modeSelectPin <= (k == 1);
				repeat (6) @(posedge clk);
				chk("opMode", {30'h0, expMode(cm, k == 1)}, {30'h0, opMode});
				chk("torqueOp", {31'h0, expMode(cm, k == 1) == 2'h3}, {31'h0, torqueOp});
			end
		end
		$display("test modes done");
		// random scale and input, as command then as limit; 20 mV offset is two steps of r
		for (k = 0; k < 8; k++) begin
			sc = $random(seed) % 1001;
			r = $random(seed) % 1001;
			analogIn <= 16'(r * 10);
			acc(1'b1, `DMT_IDX_TQ_SCALE, sc[15:0], 1'b0);
			acc(1'b1, `DMT_IDX_LIMIT_FUNC, 16'h0004, 1'b0);
			acc(1'b1, `DMT_IDX_CTRL_MODE, 16'h0003, 1'b0);
			repeat (6) @(posedge clk);
			chk("torqueCmd", sc * (r - 2), torqueCmd);
			chk("torqueCmdValid", 32'h0000_0001, {31'h0, torqueCmdValid});
			chk("torqueLimitOn", 32'h0000_0000, {31'h0, torqueLimitOn});
			chk("torqueLimit", 32'h0000_0000, torqueLimit);
			acc(1'b1, `DMT_IDX_CTRL_MODE, 16'h0001, 1'b0);
			repeat (6) @(posedge clk);
			chk("torqueLimit", (sc * (r - 2) < 0) ? -(sc * (r - 2)) : sc * (r - 2), torqueLimit);
			chk("torqueLimitOn", 32'h0000_0001, {31'h0, torqueLimitOn});
			chk("torqueCmd", 32'h0000_0000, torqueCmd);
			chk("torqueCmdValid", 32'h0000_0000, {31'h0, torqueCmdValid});
			acc(1'b1, `DMT_IDX_LIMIT_FUNC, 16'h0000, 1'b0);
		end
		$display("test torque done");
		// speed cap sources in torque operation
		acc(1'b1, `DMT_IDX_CTRL_MODE, 16'h0003, 1'b0);
		acc(1'b1, `DMT_IDX_SPD_LIMIT, 16'h05dc, 1'b0);
		acc(1'b1, `DMT_IDX_SPD_SRC, 16'h0000, 1'b0);
		repeat (6) @(posedge clk);
		chk("speedLimit", 32'h0000_05dc, {16'h0000, speedLimit});
		acc(1'b1, `DMT_IDX_SPD_SRC, 16'h0001, 1'b0);
		acc(1'b1, `DMT_IDX_SPD_SRC, 16'h0002, 1'b1);
		repeat (6) @(posedge clk);
		chk("speedLimit", 32'h0000_0bb8, {16'h0000, speedLimit});
		$display("test speed done");
		final_report;
	end
endmodule
`default_nettype wire
